/* vhp_device_end.sv */
// video processor host port: registers, status and memory pointer
// Overview of operation
// - eight write-only registers, one readable status
// - mode bits pick tiled, block or text
// - register 2 low nibble gives name base
// - register 3 gives colour table upper bits
// - tiled two: host writes FF or 7F
// - register 4 low three bits: pattern base
// - register 5 low seven bits: sprite attributes
// - register 6 low three bits: sprite patterns
// - register 7 nibbles give text colours
// - colours are four-bit codes
// - frame end sets flag, interrupt if enabled
// - fifth sprite flag and number when frame clear
// - sprite overlap sets collision flag
// - flags sticky until reset or status read
// - register load is data then command
// - byte taken on write strobe rising edge
// - drive bus during read strobe, until the clock edge that sees it rise
// - select low for memory data only
// - write setup: low byte, then 01 high
// - pointer is 14 bits, increments per byte
// - status read single byte, select high
// - read setup uses 00 high bits
`timescale 1ns/1ps
`default_nettype none
module vhp_device_end
  import vhp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic frame_end,
  input wire logic fifth_hit,
  input wire logic [4:0] fifth_num,
  input wire logic sprite_overlap,
  input wire logic [7:0] mem_rdata,
  output logic [13:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  output vhp_mode_e disp_mode,
  output logic [13:0] name_base,
  output logic [13:0] colour_base,
  output logic [13:0] pattern_base,
  output logic [13:0] sprite_attr_base_addr,
  output logic [13:0] sprite_pat_base,
  output logic [3:0] fg_colour,
  output logic [3:0] backdrop_colour,
  vhp_bus_if.dev bus
);
  import vhp_pkg::*;
  logic [7:0] regs_r [VHP_NREG];
  logic [7:0] stat_r, first_r, rbuf_r;
  logic [13:0] ptr_r;
  logic wsn_d_r, rsn_d_r, pair_r, re_d_r;
  vhp_mode_e mode_now;

  // one decoder feeds mode, colour base and text colour, so they never disagree
  function automatic vhp_mode_e decode_mode(input logic [2:0] bits);
    case (bits)
      3'b001: decode_mode = VHP_MODE_TILED_TWO;
      3'b010: decode_mode = VHP_MODE_BLOCK;
      3'b100: decode_mode = VHP_MODE_TEXT;
      // undefined mixes fall back to the plain tiled mode
      default: decode_mode = VHP_MODE_TILED_ONE;
    endcase
  endfunction

  wire soft_rst = !bus.reset_ext_n;
  wire wr_rise = !wsn_d_r && bus.write_strobe_n;
  wire rd_fall = rsn_d_r && !bus.read_strobe_n;
  wire rd_rise = !rsn_d_r && bus.read_strobe_n;
  wire [7:0] din = bus.data;
  wire data_wr = wr_rise && !bus.mode;
  wire ctl_wr = wr_rise && bus.mode;
  wire second = ctl_wr && pair_r;
  wire reg_ld = second && din[7:6] == VHP_CMD_REG;
  wire addr_ld = second && (din[7:6] == VHP_CMD_WRITE || din[7:6] == VHP_CMD_READ);
  wire stat_rd = rd_rise && bus.mode;
  wire data_rd = rd_rise && !bus.mode;
  wire pair_clr = stat_rd || data_wr || data_rd;
  wire [2:0] mode_bits = {regs_r[1][VHP_R1_MODE_A_BIT], regs_r[1][VHP_R1_MODE_B_BIT],
    regs_r[0][VHP_R0_MODE_C_BIT]};
  assign mode_now = decode_mode(mode_bits);
  wire is_tiled_two = mode_now == VHP_MODE_TILED_TWO;
  wire is_text = mode_now == VHP_MODE_TEXT;
  // pointer wraps at the top of the 14-bit space
  wire [13:0] ptr_inc = ptr_r + 14'h0001;
  wire [13:0] setup_addr = {din[5:0], first_r};
  wire fetch_first = addr_ld && din[7:6] == VHP_CMD_READ;
  // flag set wins over clear from a read in the same cycle
  wire [7:0] stat_set = {frame_end, fifth_hit && !stat_r[VHP_ST_FRAME_BIT] && !stat_r[VHP_ST_FIFTH_BIT],
    sprite_overlap, 5'h00};
  // a read clears only the flags it showed; one raised while the byte stood survives
  wire [2:0] flags_kept = stat_rd ? (stat_r[7:5] & ~bus.data_d[7:5]) : stat_r[7:5];
  wire [2:0] flags_nxt = flags_kept | stat_set[7:5];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wsn_d_r <= 1'b1;
      rsn_d_r <= 1'b1;
      re_d_r <= 1'b0;
    end else begin
      wsn_d_r <= bus.write_strobe_n;
      rsn_d_r <= bus.read_strobe_n;
      // memory answers in the cycle after the fetch strobe
      re_d_r <= mem_re;
    end
  end

  for (genvar i = 0; i < VHP_NREG; i++) begin : g_reg
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) regs_r[i] <= VHP_REG_RESET;
      else if (soft_rst) regs_r[i] <= VHP_REG_RESET;
      else if (reg_ld && din[2:0] == 3'(i)) regs_r[i] <= first_r;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stat_r <= VHP_STAT_RESET;
    end else if (soft_rst) begin
      stat_r <= VHP_STAT_RESET;
    end else begin
      stat_r[7:5] <= flags_nxt;
      if (stat_set[VHP_ST_FIFTH_BIT]) stat_r[4:0] <= fifth_num;
    end
  end

  // first control byte is parked until its partner decides what it is
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pair_r <= 1'b0;
      first_r <= 8'h00;
    end else if (soft_rst) begin
      pair_r <= 1'b0;
    end else if (ctl_wr) begin
      pair_r <= !pair_r;
      if (!pair_r) first_r <= din;
    end else if (pair_clr) begin
      pair_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= 14'h0000;
    end else if (addr_ld) begin
      ptr_r <= setup_addr;
    end else if (data_wr || data_rd) begin
      ptr_r <= ptr_inc;
    end
  end

  // a read setup fetches at once so the first data read answers without a wait
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_addr <= 14'h0000;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
      mem_re <= 1'b0;
    end else begin
      mem_we <= data_wr;
      mem_re <= fetch_first || data_rd;
      if (addr_ld) mem_addr <= setup_addr;
      else if (data_wr) mem_addr <= ptr_r;
      else if (data_rd) mem_addr <= ptr_inc;
      if (data_wr) mem_wdata <= din;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rbuf_r <= 8'h00;
    else if (re_d_r) rbuf_r <= mem_rdata;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.data_d <= 8'h00;
      bus.data_d_oe <= 1'b0;
      bus.irq_n <= 1'b1;
    end else begin
      // drive stops on the edge that sees the strobe rise, never later
      bus.data_d_oe <= !bus.read_strobe_n && !rd_rise;
      if (rd_fall) bus.data_d <= bus.mode ? stat_r : rbuf_r;
      bus.irq_n <= !(stat_r[VHP_ST_FRAME_BIT] && regs_r[1][VHP_R1_IRQ_EN_BIT]);
    end
  end

  // base outputs are byte addresses of each table
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      disp_mode <= VHP_MODE_TILED_ONE;
      name_base <= 14'h0000;
      colour_base <= 14'h0000;
      pattern_base <= 14'h0000;
      sprite_attr_base_addr <= 14'h0000;
      sprite_pat_base <= 14'h0000;
      fg_colour <= 4'h0;
      backdrop_colour <= 4'h0;
    end else begin
      disp_mode <= mode_now;
      name_base <= {regs_r[2][3:0], 10'h000};
      // tiled two uses top bit only; host sets rest to ones
      colour_base <= is_tiled_two ? {regs_r[3][7], 13'h0000} : {regs_r[3], 6'h00};
      pattern_base <= {regs_r[4][2:0], 11'h000};
      sprite_attr_base_addr <= {regs_r[5][6:0], 7'h00};
      sprite_pat_base <= {regs_r[6][2:0], 11'h000};
      // colour codes pass as 4-bit values
      fg_colour <= is_text ? regs_r[7][7:4] : 4'h0;
      backdrop_colour <= regs_r[7][3:0];
    end
  end
endmodule
`default_nettype wire

/* vhp_pkg.sv */
// constants and types shared by the host port ends
package vhp_pkg;
  localparam int unsigned VHP_DW = 8;
  localparam int unsigned VHP_AW = 14;
  localparam int unsigned VHP_NREG = 8;
  // register 0 / 1 field positions
  localparam int unsigned VHP_R0_MODE_C_BIT = 1;
  localparam int unsigned VHP_R1_IRQ_EN_BIT = 5;
  localparam int unsigned VHP_R1_MODE_A_BIT = 4;
  localparam int unsigned VHP_R1_MODE_B_BIT = 3;
  // status field positions
  localparam int unsigned VHP_ST_FRAME_BIT = 7;
  localparam int unsigned VHP_ST_FIFTH_BIT = 6;
  localparam int unsigned VHP_ST_COLL_BIT = 5;
  localparam int unsigned VHP_SPR_NUM_W = 5;
  // second setup byte codes in bits 7:6
  localparam logic [1:0] VHP_CMD_READ = 2'h0;
  localparam logic [1:0] VHP_CMD_WRITE = 2'h1;
  localparam logic [1:0] VHP_CMD_REG = 2'h2;
  localparam logic [7:0] VHP_REG_RESET = 8'h00;
  localparam logic [7:0] VHP_STAT_RESET = 8'h00;
  // host command port offsets
  localparam logic [3:0] VHP_H_CTRL = 4'h0;
  localparam logic [3:0] VHP_H_DATA = 4'h1;
  localparam logic [3:0] VHP_H_ADDR_LO = 4'h2;
  localparam logic [3:0] VHP_H_ADDR_HI = 4'h3;
  localparam logic [3:0] VHP_H_STATUS = 4'h4;
  localparam logic [3:0] VHP_H_RDATA = 4'h5;
  // host ctrl command codes
  localparam logic [2:0] VHP_OP_REG = 3'h1;
  localparam logic [2:0] VHP_OP_SETW = 3'h2;
  localparam logic [2:0] VHP_OP_SETR = 3'h3;
  localparam logic [2:0] VHP_OP_WDATA = 3'h4;
  localparam logic [2:0] VHP_OP_RDATA = 3'h5;
  localparam logic [2:0] VHP_OP_STAT = 3'h6;
  // strobe low time in clocks
  localparam int unsigned VHP_STROBE_CYC = 2;
  typedef enum logic [1:0] {
    VHP_MODE_TILED_ONE,
    VHP_MODE_TILED_TWO,
    VHP_MODE_BLOCK,
    VHP_MODE_TEXT
  } vhp_mode_e;
endpackage

/* vhp_bus_if.sv */
// pin level carrier between host and video processor
`timescale 1ns/1ps
`default_nettype none
interface vhp_bus_if;
  logic [7:0] data_h;
  logic data_h_oe;
  logic [7:0] data_d;
  logic data_d_oe;
  logic write_strobe_n;
  logic read_strobe_n;
  logic mode;
  logic irq_n;
  logic reset_ext_n;
  wire [7:0] data = data_d_oe ? data_d : (data_h_oe ? data_h : 8'hFF);
  modport dev (input data, input write_strobe_n, input read_strobe_n, input mode, input reset_ext_n,
    output data_d, output data_d_oe, output irq_n);
  modport host (input data, input irq_n, output data_h, output data_h_oe, output write_strobe_n,
    output read_strobe_n, output mode, output reset_ext_n);
endinterface
`default_nettype wire

/* vhp_host_end.sv */
// host side sequencer driving the processor port
`timescale 1ns/1ps
`default_nettype none
module vhp_host_end
  import vhp_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq_seen,
  vhp_bus_if.host bus
);
  import vhp_pkg::*;
  typedef enum logic [2:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_NEXT} vhp_hs_e;
  vhp_hs_e st_r;
  logic [2:0] op_r;
  logic [7:0] data_r, alo_r, ahi_r, stat_r, rd_r;
  logic [1:0] cnt_r, nbytes_r;
  logic is_rd_r, sel_r, busy_r;
  logic [7:0] byte_sel;
  // written bytes: pick which byte of the sequence goes out
  // first byte of every pair is the parked low byte: register value or address low
  assign byte_sel = (nbytes_r == 2'd2) ? alo_r :
    (op_r == VHP_OP_REG ? {1'b1, 4'h0, data_r[2:0]} :
     (op_r == VHP_OP_WDATA ? data_r : ahi_r));
  wire go = wr && addr == VHP_H_CTRL && !busy_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= HS_IDLE;
      op_r <= 3'h0;
      data_r <= 8'h00;
      alo_r <= 8'h00;
      ahi_r <= 8'h00;
      stat_r <= 8'h00;
      rd_r <= 8'h00;
      cnt_r <= 2'd0;
      nbytes_r <= 2'd0;
      is_rd_r <= 1'b0;
      sel_r <= 1'b1;
      busy_r <= 1'b0;
      rdata <= 8'h00;
      irq_seen <= 1'b0;
      bus.data_h <= 8'h00;
      bus.data_h_oe <= 1'b0;
      bus.write_strobe_n <= 1'b1;
      bus.read_strobe_n <= 1'b1;
      bus.mode <= 1'b1;
      bus.reset_ext_n <= 1'b1;
    end else begin
      irq_seen <= !bus.irq_n;
      if (wr && addr == VHP_H_DATA) data_r <= wdata;
      if (wr && addr == VHP_H_ADDR_LO) alo_r <= wdata;
      if (wr && addr == VHP_H_ADDR_HI) ahi_r <= {2'b00, wdata[5:0]};
      if (rd) rdata <= addr == VHP_H_STATUS ? stat_r : (addr == VHP_H_RDATA ? rd_r : {7'h00, busy_r});
      case (st_r)
        HS_IDLE: begin
          if (go) begin
            op_r <= wdata[2:0];
            busy_r <= 1'b1;
            st_r <= HS_LOW;
            cnt_r <= 2'd0;
            is_rd_r <= wdata[2:0] == VHP_OP_RDATA || wdata[2:0] == VHP_OP_STAT;
            sel_r <= !(wdata[2:0] == VHP_OP_WDATA || wdata[2:0] == VHP_OP_RDATA);
            nbytes_r <= (wdata[2:0] == VHP_OP_REG || wdata[2:0] == VHP_OP_SETW ||
              wdata[2:0] == VHP_OP_SETR) ? 2'd2 : 2'd1;
            if (wdata[2:0] == VHP_OP_SETW) ahi_r <= {VHP_CMD_WRITE, ahi_r[5:0]};
            if (wdata[2:0] == VHP_OP_SETR) ahi_r <= {VHP_CMD_READ, ahi_r[5:0]};
          end
        end
        HS_LOW: begin
          bus.mode <= sel_r;
          if (is_rd_r) begin
            bus.read_strobe_n <= 1'b0;
          end else begin
            bus.data_h <= byte_sel;
            bus.data_h_oe <= 1'b1;
            bus.write_strobe_n <= 1'b0;
          end
          st_r <= HS_HIGH;
        end
        HS_HIGH: begin
          cnt_r <= cnt_r + 2'd1;
          if (cnt_r == 2'(VHP_STROBE_CYC - 1)) begin
            if (is_rd_r && op_r == VHP_OP_STAT) stat_r <= bus.data;
            if (is_rd_r && op_r == VHP_OP_RDATA) rd_r <= bus.data;
            bus.write_strobe_n <= 1'b1;
            bus.read_strobe_n <= 1'b1;
            st_r <= HS_NEXT;
          end
        end
        HS_NEXT: begin
          bus.data_h_oe <= 1'b0;
          bus.mode <= 1'b1;
          cnt_r <= 2'd0;
          if (nbytes_r == 2'd2) begin
            nbytes_r <= 2'd1;
            st_r <= HS_LOW;
          end else begin
            busy_r <= 1'b0;
            st_r <= HS_IDLE;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* vhp_bus_monitor.sv */
// pin level checks on the host port carrier
`timescale 1ns/1ps
`default_nettype none
module vhp_bus_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] data,
  input wire logic data_d_oe,
  input wire logic data_h_oe,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic mode,
  input wire logic irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_one_driver: assert property (!(data_d_oe && data_h_oe))
    else $error("both ends drive data");
  chk_read_drives: assert property ($fell(read_strobe_n) |=> data_d_oe)
    else $error("device not driving during read");
  chk_bus_released: assert property (read_strobe_n && $past(read_strobe_n) && $past(read_strobe_n, 2)
    |-> !data_d_oe)
    else $error("device drives idle bus");
  chk_read_steady: assert property (data_d_oe && $past(data_d_oe) |-> $stable(data))
    else $error("read byte changed");
  chk_strobes_apart: assert property (write_strobe_n || read_strobe_n)
    else $error("strobes overlap");
  chk_host_presents: assert property (!write_strobe_n |-> data_h_oe)
    else $error("write without data");
  chk_write_hold: assert property (!write_strobe_n && !$past(write_strobe_n)
    |-> $stable(data) && $stable(mode))
    else $error("write byte moved");
  chk_write_len: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("write strobe length");
  chk_read_len: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*2] ##1 read_strobe_n)
    else $error("read strobe length");
  chk_read_mode: assert property (!read_strobe_n && !$past(read_strobe_n) |-> $stable(mode))
    else $error("select moved in read");
  chk_irq_cleared: assert property ($rose(read_strobe_n) && mode && !irq_n |-> ##[1:4] irq_n)
    else $error("status read left interrupt");
  cov_status_read: cover property ($rose(read_strobe_n) && mode);
  cov_data_read: cover property ($rose(read_strobe_n) && !mode);
  cov_irq: cover property ($fell(irq_n));
endmodule
`default_nettype wire

/* tb_video_processor_host_port.sv */
// self-checking bench for both ends of the host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module tb_video_processor_host_port;
  import vhp_pkg::*;
  logic clk = 0, reset_n = 0, wr = 0, rd = 0, ck = 0, ck_d = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, mem_rdata = 0, rdata, v, mem_wdata, rexp;
  logic frame_end = 0, fifth_hit = 0, sprite_overlap = 0, irq_seen, mem_we, mem_re;
  logic [4:0] fifth_num = 0;
  logic [13:0] mem_addr, nb, cb, pb, sab, spb;
  logic [3:0] fg, bd;
  vhp_mode_e dm;
  logic [15:0] lfsr = 16'h3519;
  int mismatches = 0, total_checks = 0;
  logic [7:0] rq[$];
  logic [21:0] wq[$];
  logic [21:0] wexp;
  vhp_bus_if vhp_bus_if_i ();
  always #2.5 clk = ~clk;
  vhp_host_end vhp_host_end_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq_seen(irq_seen), .bus(vhp_bus_if_i.host));
  vhp_device_end vhp_device_end_i (.clk(clk), .reset_n(reset_n), .frame_end(frame_end), .fifth_hit(fifth_hit),
    .fifth_num(fifth_num), .sprite_overlap(sprite_overlap), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .disp_mode(dm), .name_base(nb),
    .colour_base(cb), .pattern_base(pb), .sprite_attr_base_addr(sab), .sprite_pat_base(spb),
    .fg_colour(fg), .backdrop_colour(bd), .bus(vhp_bus_if_i.dev));
  vhp_bus_monitor vhp_bus_monitor_i (.clk(clk), .reset_n(reset_n), .data(vhp_bus_if_i.data),
    .data_d_oe(vhp_bus_if_i.data_d_oe), .data_h_oe(vhp_bus_if_i.data_h_oe),
    .write_strobe_n(vhp_bus_if_i.write_strobe_n), .read_strobe_n(vhp_bus_if_i.read_strobe_n),
    .mode(vhp_bus_if_i.mode), .irq_n(vhp_bus_if_i.irq_n));
  // memory answers the cycle after a fetch; watcher pops the oldest note
  always @(posedge clk) begin
    if (mem_re) mem_rdata <= mem_addr[7:0] ^ 8'hA5;
    if (ck_d) rexp = rq.pop_front();
    if (ck_d) `CHK(rdata, rexp)
    ck_d <= rd && ck;
    if (mem_we) wexp = wq.pop_front();
    if (mem_we) `CHK({mem_addr, mem_wdata}, wexp)
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one strobe, then a gap so no signal is driven twice in a step
  task automatic bus_op(input logic [3:0] a, input logic [7:0] d, input logic w, input logic c);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    ck <= c;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic op(input logic [2:0] c);
    int n;
    bus_op(VHP_H_CTRL, {5'h0, c}, 1, 0);
    n = 0;
    do begin
      bus_op(VHP_H_CTRL, 8'h00, 0, 0);
      n++;
    end while (v[0] !== 1'b0 && n < 200);
    if (v[0] !== 1'b0) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic set_reg(input logic [2:0] r, input logic [7:0] d);
    bus_op(VHP_H_ADDR_LO, d, 1, 0);
    bus_op(VHP_H_DATA, {5'h0, r}, 1, 0);
    op(VHP_OP_REG);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    rq.push_back(e);
    bus_op(a, 8'h00, 0, 1);
  endtask
  task automatic pulse(input logic f, input logic s, input logic o, input logic [4:0] k);
    frame_end <= f;
    fifth_hit <= s;
    sprite_overlap <= o;
    fifth_num <= k;
    @(posedge clk);
    frame_end <= 0;
    fifth_hit <= 0;
    sprite_overlap <= 0;
    @(posedge clk);
  endtask
  initial begin
    logic [7:0] x;
    repeat (6) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    for (int m = 0; m < 4; m++) begin
      x = rnd();
      set_reg(0, (m == 1) ? 8'h02 : 8'h00);
      set_reg(1, (m == 3) ? 8'h10 : (m == 2) ? 8'h08 : 8'h00);
      set_reg(7, x);
      `CHK(dm, vhp_mode_e'(m))
      `CHK({fg, bd}, {(m == 3) ? x[7:4] : 4'h0, x[3:0]})
    end
    $display("modes done");
    set_reg(2, 8'h01);
    `CHK(nb, 14'h0400)
    set_reg(4, 8'h01);
    `CHK(pb, 14'h0800)
    set_reg(5, 8'h0E);
    `CHK(sab, 14'h0700)
    x = rnd() & 8'h07;
    set_reg(6, x);
    `CHK(spb, {x[2:0], 11'h000})
    set_reg(1, 8'h00);
    set_reg(0, 8'h02);
    set_reg(3, 8'hFF);
    `CHK(cb, 14'h2000)
    set_reg(3, 8'h7F);
    `CHK(cb, 14'h0000)
    set_reg(0, 8'h00);
    set_reg(3, 8'h1E);
    `CHK(cb, 14'h0780)
    $display("bases done");
    // top address first, so the pointer must wrap to zero
    bus_op(VHP_H_ADDR_LO, 8'hFF, 1, 0);
    bus_op(VHP_H_ADDR_HI, 8'h3F, 1, 0);
    op(VHP_OP_SETW);
    for (int i = 0; i < 3; i++) begin
      x = rnd();
      wq.push_back({14'(14'h3FFF + i), x});
      bus_op(VHP_H_DATA, x, 1, 0);
      op(VHP_OP_WDATA);
    end
    `CHK(wq.size(), 0)
    bus_op(VHP_H_ADDR_LO, 8'h34, 1, 0);
    bus_op(VHP_H_ADDR_HI, 8'h12, 1, 0);
    op(VHP_OP_SETR);
    for (int i = 0; i < 2; i++) begin
      op(VHP_OP_RDATA);
      rchk(VHP_H_RDATA, 8'(8'h34 + i) ^ 8'hA5);
    end
    $display("memory done");
    pulse(0, 1, 1, 5'h13);
    pulse(1, 0, 0, 5'h00);
    repeat (3) @(posedge clk);
    `CHK(irq_seen, 1'b0)
    op(VHP_OP_STAT);
    rchk(VHP_H_STATUS, 8'hF3);
    op(VHP_OP_STAT);
    rchk(VHP_H_STATUS, 8'h13);
    set_reg(1, 8'h20);
    pulse(1, 0, 0, 5'h00);
    pulse(0, 1, 0, 5'h13);
    repeat (3) @(posedge clk);
    `CHK(irq_seen, 1'b1)
    op(VHP_OP_STAT);
    rchk(VHP_H_STATUS, 8'h93);
    repeat (4) @(posedge clk);
    `CHK(irq_seen, 1'b0)
    $display("status done");
    summarize();
  end
endmodule
`default_nettype wire
